// ==== src/sbm_pkg.sv ====
// shared constants for the burst order / mode register block
package sbm_pkg;
   // bank codes that select a mode register on a load command
   localparam logic [2:0] BANK_MODE_ZERO = 3'h0;
   localparam logic [2:0] BANK_MODE_ONE = 3'h1;
   localparam logic [2:0] BANK_MODE_TWO = 3'h2;
   // mode_reg_zero field positions
   localparam int MR0_BL_LSB = 0;
   localparam int MR0_CL_LOW = 2;
   localparam int MR0_BT = 3;
   localparam int MR0_CL_LSB = 4;
   localparam int MR0_TEST = 7;
   localparam int MR0_DLL_RST = 8;
   localparam int MR0_WR_LSB = 9;
   localparam int MR0_PPD = 12;
   // mode_reg_one and mode_reg_two field positions
   localparam int MR1_DLL_OFF = 0;
   localparam int MR1_AL_LSB = 3;
   localparam int MR2_RTTWR_LSB = 9;
   // burst length field encodings
   localparam logic [1:0] BL_FIXED_EIGHT = 2'h0;
   localparam logic [1:0] BL_ON_THE_FLY = 2'h1;
   localparam logic [1:0] BL_FIXED_CHOP = 2'h2;
   // on-the-fly chop select address bit
   localparam int ADDR_CHOP_SEL = 12;
   // additive latency encodings
   localparam logic [1:0] AL_CL_MINUS_ONE = 2'h1;
   localparam logic [1:0] AL_CL_MINUS_TWO = 2'h2;
   // latency base values
   localparam logic [3:0] CL_BASE_LOW = 4'h4;
   localparam logic [3:0] CL_BASE_HIGH = 4'hc;
   // depth of the read latency pipe, above the largest total latency
   localparam int RD_PIPE_DEPTH = 32;
   // cycles from write command to internal write for an eight-beat write
   localparam logic [3:0] WR_INT_BASE = 4'h8;
   localparam logic [3:0] WR_CHOP_PULL_IN = 4'h2;
   localparam int WR_PIPE_DEPTH = 16;
   // reset values of the mode registers
   localparam logic [15:0] MODE_REG_RESET = 16'h0000;
endpackage : sbm_pkg

// ==== src/sbm_burst_if.sv ====
// link between the command decoder and the burst beat sequencer
`timescale 1ns/1ps
interface sbm_burst_if;
   logic start;
   logic [2:0] col;
   logic chop;
   logic ilv;
   logic [2:0] beat_col;
   logic beat_valid;
   logic drive;
   modport ctl (output start, col, chop, ilv,
                input beat_col, beat_valid, drive);
   modport seq (input start, col, chop, ilv,
                output beat_col, beat_valid, drive);
endinterface : sbm_burst_if

// ==== src/sbm_burst_seq.sv ====
// read burst beat sequencer: one beat slot per clock, eight slots per burst
`timescale 1ns/1ps
module sbm_burst_seq
   import sbm_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   sbm_burst_if.seq bus
);
   typedef struct packed {
      logic busy;
      logic [2:0] cnt;
      logic [2:0] col;
      logic chop;
      logic ilv;
      logic [2:0] beat_col;
      logic beat_valid;
      logic drive;
   } sbm_seq_state_t;

   sbm_seq_state_t s_q;
   sbm_seq_state_t s_d;

   // column of beat i for a given start column and burst type
   function automatic logic [2:0] beat_order(input logic [2:0] c,
                                             input logic [2:0] i,
                                             input logic il);
      logic [1:0] low;
      low = c[1:0] + i[1:0];
      if (il) begin
         beat_order = c ^ i; // see [R2]
      end else begin
         beat_order = {c[2] ^ i[2], low}; // see [R2]
      end
   endfunction : beat_order

   // next state: start a burst or walk the current one
   always_comb begin
      s_d = s_q;
      s_d.beat_valid = 1'b0;
      s_d.drive = 1'b0;
      if (bus.start) begin
         s_d.busy = 1'b1;
         s_d.cnt = 3'h1;
         s_d.col = bus.col;
         s_d.chop = bus.chop;
         s_d.ilv = bus.ilv;
         s_d.beat_col = bus.col; // see [R2]
         s_d.beat_valid = 1'b1;
         s_d.drive = 1'b1;
      end else if (s_q.busy) begin
         s_d.beat_col = beat_order(s_q.col, s_q.cnt, s_q.ilv);
         s_d.beat_valid = 1'b1;
         s_d.drive = ~(s_q.chop & s_q.cnt[2]); // see [R1]
         s_d.cnt = s_q.cnt + 3'h1;
         s_d.busy = (s_q.cnt != 3'h7);
      end
   end

   // state register
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign bus.beat_col = s_q.beat_col;
   assign bus.beat_valid = s_q.beat_valid;
   assign bus.drive = s_q.drive;
endmodule : sbm_burst_seq

// ==== src/sbm_mode_core.sv ====
// command decode, mode registers, latency pipes and dll control
// How it works
// [R1] chopped read: four beats, then four idle slots
// [R2] first beat from column; sequential wrap or xor
// [R3] writes ignore low column bits, chop uses bit2
// [R4] fixed chop: internal write two clocks earlier
// [R5] on-the-fly chop: internal write at eight-beat time
// [R6] column latency field sets whole-clock read delay
// [R7] total read latency is additive plus column
// [R8] controller keeps test bit clear
// [R9] dll reset bit clears itself
// [R10] controller waits lock time after dll reset
// [R11] write recovery plus precharge gives autoprecharge delay
// [R12] slow exit freezes dll in power-down
// [R13] fast exit keeps dll running in power-down
// [R14] bank code one loads mode_reg_one
// [R15] controller zeroes reserved mode_reg_one bits
// [R16] write leveling limits termination unless outputs off
// [R17] write termination limited to three resistor settings
// [R18] dll off in self refresh, back on after
// [R19] controller enables dll and holds clock enable
// [R20] writes need dll only with dynamic termination
// [R21] dll-off: controller disables nominal termination
// [R22] dll-off: controller disables dynamic termination
// [R23] bank code zero loads mode_reg_zero
// [R24] burst length field: eight, chop, on-the-fly
// [R25] address bit eight requests dll reset
// [R26] decoded fields held until next load
`timescale 1ns/1ps
module sbm_mode_core
   import sbm_pkg::*;
(
   input wire logic CORE_CLK_IN,
   input wire logic SYS_RST_IN,
   input wire logic CS_N_IN,
   input wire logic RAS_N_IN,
   input wire logic CAS_N_IN,
   input wire logic WE_N_IN,
   input wire logic [2:0] BA_IN,
   input wire logic [15:0] ADDR_IN,
   input wire logic SELF_REFRESH_IN,
   input wire logic POWERDOWN_IN,
   input wire logic [4:0] PRECHARGE_PERIOD_IN,
   output logic [2:0] RD_BEAT_COL_OUT,
   output logic RD_BEAT_VALID_OUT,
   output logic RD_DRIVE_EN_OUT,
   output logic WR_UPPER_HALF_OUT,
   output logic WR_CHOP_OUT,
   output logic WR_INTERNAL_OUT,
   output logic [4:0] TOTAL_READ_LATENCY_OUT,
   output logic [5:0] AUTOPRECHARGE_WRITE_DELAY_OUT,
   output logic DLL_RESET_OUT,
   output logic DLL_RUN_OUT,
   output logic TEST_MODE_OUT,
   output logic WR_TERM_OK_OUT,
   output logic [15:0] MODE_REG_ZERO_OUT,
   output logic [15:0] MODE_REG_ONE_OUT
);
   // one pending read: valid, chop, interleave, start column
   typedef struct packed {
      logic valid;
      logic chop;
      logic ilv;
      logic [2:0] col;
   } sbm_rd_entry_t;

   typedef struct packed {
      logic [15:0] mode_reg_zero;
      logic [15:0] mode_reg_one;
      logic [1:0] rtt_wr;
      logic dll_reset;
      logic [RD_PIPE_DEPTH-1:0][5:0] rd_pipe;
      logic [WR_PIPE_DEPTH-1:0] wr_pipe;
      logic wr_upper;
      logic wr_chop;
      logic wr_internal;
      logic dll_run;
   } sbm_core_state_t;

   sbm_core_state_t s_q;
   sbm_core_state_t s_d;
   sbm_burst_if burst ();

   logic cmd_sel;
   logic cmd_mrs;
   logic cmd_read;
   logic cmd_write;
   logic [4:0] cl; // up to 12 + 7, one bit wider than the base constants
   logic [4:0] al;
   logic [4:0] rl;
   logic [4:0] wr_cycles;
   logic [1:0] bl_field;
   logic cmd_chop;
   sbm_rd_entry_t head;

   // command decode from the sampled command pins
   assign cmd_sel = ~CS_N_IN & ~RAS_N_IN & ~CAS_N_IN;
   assign cmd_mrs = cmd_sel & ~WE_N_IN;
   assign cmd_read = ~CS_N_IN & RAS_N_IN & ~CAS_N_IN & WE_N_IN;
   assign cmd_write = ~CS_N_IN & RAS_N_IN & ~CAS_N_IN & ~WE_N_IN;

   // latency decode from the held mode registers
   always_comb begin
      if (s_q.mode_reg_zero[MR0_CL_LOW]) begin
         cl = {1'b0, CL_BASE_HIGH} +
            {2'h0, s_q.mode_reg_zero[MR0_CL_LSB +: 3]};
      end else begin
         cl = {1'b0, CL_BASE_LOW} +
            {2'h0, s_q.mode_reg_zero[MR0_CL_LSB +: 3]};
      end // see [R6]
      if (s_q.mode_reg_one[MR1_AL_LSB +: 2] == AL_CL_MINUS_ONE) begin
         al = cl - 5'h01;
      end else if (s_q.mode_reg_one[MR1_AL_LSB +: 2] == AL_CL_MINUS_TWO) begin
         al = cl - 5'h02;
      end else begin
         al = 5'h00;
      end
      // sum wraps above 31: largest latency with largest additive is unusable
      rl = al + cl; // see [R7]
   end

   // write recovery field to clocks
   always_comb begin
      case (s_q.mode_reg_zero[MR0_WR_LSB +: 3])
         3'h0: wr_cycles = 5'h10;
         3'h1: wr_cycles = 5'h05;
         3'h2: wr_cycles = 5'h06;
         3'h3: wr_cycles = 5'h07;
         3'h4: wr_cycles = 5'h08;
         3'h5: wr_cycles = 5'h0a;
         3'h6: wr_cycles = 5'h0c;
         default: wr_cycles = 5'h0e;
      endcase
   end

   // chop choice for the command now on the pins
   assign bl_field = s_q.mode_reg_zero[MR0_BL_LSB +: 2];
   assign cmd_chop = (bl_field == BL_FIXED_CHOP) |
      ((bl_field == BL_ON_THE_FLY) & ~ADDR_IN[ADDR_CHOP_SEL]); // see [R24]
   assign head = sbm_rd_entry_t'(s_q.rd_pipe[0]);

   // next state of the whole core
   always_comb begin
      s_d = s_q;
      s_d.dll_reset = 1'b0; // see [R9]
      s_d.mode_reg_zero[MR0_DLL_RST] = 1'b0; // see [R9]
      s_d.wr_internal = s_q.wr_pipe[0];
      s_d.rd_pipe = s_q.rd_pipe >> 6;
      s_d.wr_pipe = s_q.wr_pipe >> 1;
      if (cmd_mrs) begin
         if (BA_IN == BANK_MODE_ZERO) begin
            s_d.mode_reg_zero = ADDR_IN; // see [R23] [R26]
            s_d.dll_reset = ADDR_IN[MR0_DLL_RST]; // see [R25]
         end else if (BA_IN == BANK_MODE_ONE) begin
            s_d.mode_reg_one = ADDR_IN; // see [R14] [R26]
         end else if (BA_IN == BANK_MODE_TWO) begin
            s_d.rtt_wr = ADDR_IN[MR2_RTTWR_LSB +: 2];
         end
      end else if (cmd_read && rl != 5'h00) begin
         s_d.rd_pipe[rl - 5'h01] = {1'b1, cmd_chop,
            s_q.mode_reg_zero[MR0_BT], ADDR_IN[2:0]};
      end else if (cmd_write) begin
         s_d.wr_chop = cmd_chop;
         s_d.wr_upper = cmd_chop & ADDR_IN[2]; // see [R3]
         if (bl_field == BL_FIXED_CHOP) begin
            s_d.wr_pipe[WR_INT_BASE - WR_CHOP_PULL_IN - 4'h1] = 1'b1; // see [R4]
         end else begin
            s_d.wr_pipe[WR_INT_BASE - 4'h1] = 1'b1; // see [R5]
         end
      end
      // dll runs when enabled, except in self refresh or slow-exit sleep
      s_d.dll_run = ~s_q.mode_reg_one[MR1_DLL_OFF] & ~SELF_REFRESH_IN &
         ~(POWERDOWN_IN & ~s_q.mode_reg_zero[MR0_PPD]); // see [R12] [R13] [R18]
   end

   // state register
   always_ff @(posedge CORE_CLK_IN) begin
      if (SYS_RST_IN) begin
         s_q <= '0;
         s_q.mode_reg_zero <= MODE_REG_RESET;
         s_q.mode_reg_one <= MODE_REG_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // hand the head of the read pipe to the beat sequencer
   assign burst.start = head.valid;
   assign burst.col = head.col; // see [R2]
   assign burst.chop = head.chop; // see [R1]
   assign burst.ilv = head.ilv;

   sbm_burst_seq u_seq (
      .clk_in (CORE_CLK_IN),
      .rst_in (SYS_RST_IN),
      .bus (burst.seq)
   );

   // outputs
   assign RD_BEAT_COL_OUT = burst.beat_col;
   assign RD_BEAT_VALID_OUT = burst.beat_valid;
   assign RD_DRIVE_EN_OUT = burst.drive; // see [R1]
   assign WR_UPPER_HALF_OUT = s_q.wr_upper;
   assign WR_CHOP_OUT = s_q.wr_chop;
   assign WR_INTERNAL_OUT = s_q.wr_internal;
   assign TOTAL_READ_LATENCY_OUT = rl;
   assign AUTOPRECHARGE_WRITE_DELAY_OUT =
      {1'b0, wr_cycles} + {1'b0, PRECHARGE_PERIOD_IN}; // see [R11]
   assign DLL_RESET_OUT = s_q.dll_reset; // see [R9]
   assign DLL_RUN_OUT = s_q.dll_run;
   assign TEST_MODE_OUT = s_q.mode_reg_zero[MR0_TEST];
   assign WR_TERM_OK_OUT = (s_q.rtt_wr == 2'h0) | s_q.dll_run; // see [R20]
   assign MODE_REG_ZERO_OUT = s_q.mode_reg_zero;
   assign MODE_REG_ONE_OUT = s_q.mode_reg_one;
endmodule : sbm_mode_core

// ==== verif/sbm_mode_core_sva.sv ====
// assertions on the ports of the mode register block
`timescale 1ns/1ps
module sbm_mode_core_sva
   import sbm_pkg::*;
(
   input wire logic CORE_CLK_IN,
   input wire logic SYS_RST_IN,
   input wire logic CS_N_IN,
   input wire logic RAS_N_IN,
   input wire logic CAS_N_IN,
   input wire logic WE_N_IN,
   input wire logic [2:0] BA_IN,
   input wire logic [15:0] ADDR_IN,
   input wire logic [2:0] RD_BEAT_COL_OUT,
   input wire logic RD_BEAT_VALID_OUT,
   input wire logic RD_DRIVE_EN_OUT,
   input wire logic WR_INTERNAL_OUT,
   input wire logic [4:0] TOTAL_READ_LATENCY_OUT,
   input wire logic DLL_RESET_OUT,
   input wire logic [15:0] MODE_REG_ZERO_OUT,
   input wire logic [15:0] MODE_REG_ONE_OUT
);
   logic [3:0] cmd;
   logic ld0, ld1;
   // command decode of the sampled pins
   assign cmd = {CS_N_IN, RAS_N_IN, CAS_N_IN, WE_N_IN};
   assign ld0 = cmd == 4'h0 && BA_IN == BANK_MODE_ZERO;
   assign ld1 = cmd == 4'h0 && BA_IN == BANK_MODE_ONE;
   default clocking @(posedge CORE_CLK_IN);
   endclocking
   default disable iff (SYS_RST_IN);
   a_mr0_load: assert property (ld0 |=>
      MODE_REG_ZERO_OUT[12:0] == $past(ADDR_IN[12:0]))
      else $error("mode_reg_zero load wrong");
   a_mr1_load: assert property (ld1 |=>
      MODE_REG_ONE_OUT[7:0] == $past(ADDR_IN[7:0]))
      else $error("mode_reg_one load wrong");
   a_mr1_hold: assert property (!ld1 |=> $stable(MODE_REG_ONE_OUT))
      else $error("mode_reg_one changed without load");
   a_dll_pulse: assert property (ld0 && ADDR_IN[MR0_DLL_RST] |=>
      DLL_RESET_OUT && MODE_REG_ZERO_OUT[MR0_DLL_RST])
      else $error("dll reset not raised");
   a_dll_selfclr: assert property (
      MODE_REG_ZERO_OUT[MR0_DLL_RST] && !(ld0 && ADDR_IN[MR0_DLL_RST])
      |=> !MODE_REG_ZERO_OUT[MR0_DLL_RST] && !DLL_RESET_OUT)
      else $error("dll reset bit stuck");
   a_rd_latency: assert property (
      cmd == 4'h5 && TOTAL_READ_LATENCY_OUT == 5'h4 && !RD_BEAT_VALID_OUT
      |-> ##4 !RD_BEAT_VALID_OUT ##1
      (RD_BEAT_VALID_OUT && RD_BEAT_COL_OUT == $past(ADDR_IN[2:0], 5)))
      else $error("first beat late or wrong column");
   a_beat_lead: assert property (
      $rose(RD_BEAT_VALID_OUT) |-> RD_DRIVE_EN_OUT[*4])
      else $error("first four beats not driven");
   a_chop_tail: assert property (
      RD_BEAT_VALID_OUT && $fell(RD_DRIVE_EN_OUT) |->
      (RD_BEAT_VALID_OUT && !RD_DRIVE_EN_OUT)[*4] ##1 !RD_BEAT_VALID_OUT)
      else $error("chop tail slots wrong");
   a_wr_fixed: assert property (
      cmd == 4'h4 && MODE_REG_ZERO_OUT[1:0] == BL_FIXED_CHOP
      |-> ##[7:8] WR_INTERNAL_OUT)
      else $error("fixed chop write start wrong");
   a_wr_otf: assert property (
      cmd == 4'h4 && MODE_REG_ZERO_OUT[1:0] == BL_ON_THE_FLY
      |-> ##[9:10] WR_INTERNAL_OUT)
      else $error("on the fly write start wrong");
endmodule : sbm_mode_core_sva
bind sbm_mode_core sbm_mode_core_sva sbm_mode_core_sva_inst (.CORE_CLK_IN,
   .SYS_RST_IN, .CS_N_IN, .RAS_N_IN, .CAS_N_IN, .WE_N_IN, .BA_IN, .ADDR_IN,
   .RD_BEAT_COL_OUT, .RD_BEAT_VALID_OUT, .RD_DRIVE_EN_OUT, .WR_INTERNAL_OUT,
   .TOTAL_READ_LATENCY_OUT, .DLL_RESET_OUT, .MODE_REG_ZERO_OUT,
   .MODE_REG_ONE_OUT);

// ==== verif/sbm_ctl_model.sv ====
// controller model: drives command, bank and address pins
`timescale 1ns/1ps
module sbm_ctl_model
   import sbm_pkg::*;
#(
   parameter int LOCK_CYCLES = 32
)(
   input wire logic clk_in,
   output logic [3:0] cmd_n_out,
   output logic [2:0] ba_out,
   output logic [15:0] addr_out
);
   // bus starts deselected
   initial begin
      cmd_n_out = 4'hf;
      ba_out = 3'h0;
      addr_out = 16'h0;
   end
   // one command for one edge, then deselect with the bus inverted
   task automatic issue(input logic [3:0] c, input logic [2:0] b,
      input logic [15:0] a);
      @(posedge clk_in);
      cmd_n_out <= c;
      ba_out <= b;
      addr_out <= a;
      @(posedge clk_in);
      cmd_n_out <= 4'hf;
      ba_out <= ~b;
      addr_out <= ~a;
   endtask : issue
   // load keeps test and reserved bits low; callers program no nominal
   // termination, which keeps the leveling and dll-off limits
   task automatic mrs(input logic [2:0] b, input logic [15:0] a);
      issue(4'h0, b, a & (b == BANK_MODE_ONE ? 16'h1aff : 16'h1f7f));
   endtask : mrs
   // no reads until the dll has locked
   task automatic lock();
      repeat (LOCK_CYCLES) @(posedge clk_in);
   endtask : lock
endmodule : sbm_ctl_model

// ==== verif/tb_sdram_burst_order_mode_regs.sv ====
// bench for burst order, latency and mode register behaviour
`timescale 1ns/1ps
module tb_sdram_burst_order_mode_regs
   import sbm_pkg::*;
();
   logic clk = 1'b0, rst = 1'b1, pdn = 1'b0, srf = 1'b0;
   logic [3:0] cmd;
   logic [2:0] ba, col, c;
   logic [15:0] addr, mr0, mr1;
   logic vld, drv, wup, wch, wint, dres, drun, tok, bt, tm;
   logic [1:0] bl;
   logic [4:0] rl;
   logic [5:0] apd;
   int miscompares = 0, total_checks = 0, n;
   int wrt[8] = '{16, 5, 6, 7, 8, 10, 12, 14};
   // 200 MHz core clock
   always #2.5 clk = ~clk;
   sbm_ctl_model sbm_ctl_model_inst (.clk_in(clk), .cmd_n_out(cmd),
      .ba_out(ba), .addr_out(addr));
   sbm_mode_core sbm_mode_core_inst (.CORE_CLK_IN(clk), .SYS_RST_IN(rst),
      .CS_N_IN(cmd[3]), .RAS_N_IN(cmd[2]), .CAS_N_IN(cmd[1]),
      .WE_N_IN(cmd[0]), .BA_IN(ba), .ADDR_IN(addr), .SELF_REFRESH_IN(srf),
      .POWERDOWN_IN(pdn), .PRECHARGE_PERIOD_IN(5'h0b),
      .RD_BEAT_COL_OUT(col), .RD_BEAT_VALID_OUT(vld), .RD_DRIVE_EN_OUT(drv),
      .WR_UPPER_HALF_OUT(wup), .WR_CHOP_OUT(wch), .WR_INTERNAL_OUT(wint),
      .TOTAL_READ_LATENCY_OUT(rl), .AUTOPRECHARGE_WRITE_DELAY_OUT(apd),
      .DLL_RESET_OUT(dres), .DLL_RUN_OUT(drun), .TEST_MODE_OUT(tm),
      .WR_TERM_OK_OUT(tok), .MODE_REG_ZERO_OUT(mr0), .MODE_REG_ONE_OUT(mr1));
   task automatic chk(input string s, input logic [15:0] e, g);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : finish_test
   // one read burst: latency, beat columns and driven slots
   task automatic rd_chk(input logic [2:0] s, input logic il, ch, a12,
      input logic [4:0] lat);
      logic [2:0] e;
      n = 0;
      sbm_ctl_model_inst.issue(4'h5, 3'h0, {3'h0, a12, 9'h0, s});
      @(negedge clk);
      while (vld !== 1'b1 && n < 64) begin
         n++;
         @(negedge clk);
      end
      chk("read latency", 16'(lat), 16'(n));
      for (int k = 0; k < 8; k++) begin
         e = il ? s ^ 3'(k) : {s[2] ^ k[2], s[1:0] + 2'(k)};
         if (!ch || k < 4) chk("beat column", 16'(e), 16'(col));
         chk("beat drive", 16'(!(ch && k > 3)), 16'(drv));
         @(negedge clk);
      end
      chk("burst end", 16'h0, 16'(vld));
   endtask : rd_chk
   // power-down and self refresh levels
   task automatic lvl(input logic p, s);
      @(posedge clk);
      pdn <= p;
      srf <= s;
      repeat (3) @(negedge clk);
   endtask : lvl
   // main sequence
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk("reset latency", 16'h4, 16'(rl));
      rd_chk(3'h5, 1'b0, 1'b0, 1'b0, 5'h4);
      for (int w = 0; w < 8; w++) begin
         sbm_ctl_model_inst.mrs(3'h0,
            {4'h0, 3'(w), 2'h0, 3'(w), 1'b0, w[0], 2'h0});
         @(negedge clk);
         chk("ap delay", 16'(wrt[w] + 11), 16'(apd));
         chk("col latency", 16'((w[0] ? 12 : 4) + w), 16'(rl));
      end
      sbm_ctl_model_inst.mrs(3'h1, 16'h0008);
      @(negedge clk);
      chk("mode one", 16'h0008, mr1);
      sbm_ctl_model_inst.mrs(3'h0, 16'h0190);
      @(negedge clk);
      chk("dll reset", 16'h3, {dres, mr0[8]});
      chk("test mode", 16'h0, 16'(tm));
      @(negedge clk);
      chk("dll clear", 16'h0, {dres, mr0[8]});
      chk("latency sum", 16'h9, 16'(rl));
      sbm_ctl_model_inst.lock();
      for (int t = 0; t < 48; t++) begin
         bl = 2'(t / 8 % 3);
         bt = t >= 24;
         c = 3'(t);
         sbm_ctl_model_inst.mrs(3'h0, {9'h0, 3'h1, bt, 1'b0, bl});
         rd_chk(c, bt, bl == BL_FIXED_CHOP || (bl == BL_ON_THE_FLY && !c[0]),
            c[0], 5'h9);
      end
      for (int t = 0; t < 6; t++) begin
         bl = 2'(t % 3);
         sbm_ctl_model_inst.mrs(3'h0, {9'h0, 3'h1, 2'h0, bl});
         sbm_ctl_model_inst.issue(4'h4, 3'h0, {13'h0, t > 2, 2'h3});
         n = 0;
         @(negedge clk);
         while (wint !== 1'b1 && n < 32) begin
            n++;
            @(negedge clk);
         end
         chk("write start", 16'(bl == BL_FIXED_CHOP ?
            WR_INT_BASE - WR_CHOP_PULL_IN : WR_INT_BASE), 16'(n));
         chk("write half", {bl != 2'h0, bl != 2'h0 && t > 2}, {wch, wup});
      end
      sbm_ctl_model_inst.mrs(3'h2, 16'h0200);
      lvl(1'b1, 1'b0);
      chk("dll slow exit", 16'h0, 16'(drun));
      lvl(1'b0, 1'b0);
      sbm_ctl_model_inst.mrs(3'h0, 16'h1010);
      lvl(1'b1, 1'b0);
      chk("dll fast exit", 16'h3, {drun, tok});
      lvl(1'b0, 1'b1);
      chk("dll self refresh", 16'h0, {drun, tok});
      lvl(1'b0, 1'b0);
      chk("dll refresh exit", 16'h1, 16'(drun));
      // dynamic termination cleared before the dll stops
      sbm_ctl_model_inst.mrs(3'h2, 16'h0000);
      lvl(1'b0, 1'b1);
      chk("term ok dll off", 16'h1, 16'(tok));
      finish_test();
   end
   // watchdog against a hang
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      finish_test();
   end
endmodule : tb_sdram_burst_order_mode_regs
